// >>> rtl/e1_tx_overhead_cfg.svh
// Register map, field positions, reset values and counts for the E1 transmit overhead block
// How it works
// - Signalling multiframe: extra bits replaced when enabled
// - Extra-bit keep set: TS16 extra bits pass
// - Basic frames: intl values into bit 1
// - Intl keep set, basic frames: bit 1 passes unchanged
// - CRC, synced, no keep: zero on error
// - CRC: intl values into E1/E2 cases
// - Both keeps set: E bits unchanged
// - Frame selections honoured only while framing on
// - Modified CRC needs CRC multiframe enabled
// - Framing off stops all frame generation
// - National codeword substituted only when enabled
// - Sa4..Sa7 codewords at 0x65..0x68
// - Basic only: first codeword bit each NFAS
// - CRC multiframe: four codeword bits per submultiframe
// - Extra values at 0x6A bits 3,1,0
// - Sa8 codeword at 0x69, enable bit 0
`ifndef E1_TX_OVERHEAD_CFG_SVH
`define E1_TX_OVERHEAD_CFG_SVH

`define REG_MODE        8'h62
`define REG_INTL        8'h63
`define REG_NAT_EN      8'h64
`define REG_NAT4        8'h65
`define REG_NAT5        8'h66
`define REG_NAT6        8'h67
`define REG_NAT7        8'h68
`define REG_NAT8        8'h69
`define REG_EXTRA       8'h6A
`define REG_POS         8'h70

`define MODE_FRAMING_OFF   0
`define MODE_CRC_ON        1
`define MODE_SIG_ON        2
`define MODE_MOD_CRC       3
`define MODE_FEBE_KEEP     4
`define MODE_INTL_KEEP     5
`define MODE_EXTRA_KEEP    6

`define MODE_RESET      7'h06
`define INTL_RESET      2'h3
`define NAT_EN_RESET    5'h00
`define CODEWORD_RESET  4'hF
`define EXTRA_RESET     3'h7

`define BITS_PER_TS     8
`define TS_PER_FRAME    32
`define FRAMES_PER_MF   16
`define TS16            5'h10

`endif

// >>> rtl/e1_tx_overhead_pkg.sv
// Types for the E1 transmit overhead block
package e1_tx_overhead_pkg;
  typedef logic [3:0] codeword_t;
  typedef enum logic [1:0] {ebit_zero_on_err, ebit_intl, ebit_keep} ebit_mode_t;
endpackage

// >>> rtl/e1_tx_overhead_insertion.sv
// E1 transmit overhead insertion with classic Wishbone register slave
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "e1_tx_overhead_cfg.svh"

module e1_tx_overhead_insertion
(
  input  wire logic       clk_i,                 // Transmit bit clock, 40 MHz
  input  wire logic       rst_i,                 // Synchronous reset, active high
  input  wire logic       wb_cyc_i,              // Wishbone cycle
  input  wire logic       wb_stb_i,              // Wishbone strobe
  input  wire logic       wb_we_i,               // Wishbone write enable
  input  wire logic [7:0] wb_adr_i,              // Wishbone byte address
  input  wire logic [3:0] wb_sel_i,              // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,             // Wishbone write data
  output logic      [31:0] wb_dat_o,             // Wishbone read data
  output logic            wb_ack_o,              // Wishbone acknowledge
  output logic            wb_err_o,              // Wishbone error, unmapped address
  input  wire logic       tx_bit_i,              // Incoming transmit data bit
  input  wire logic       tx_valid_i,            // Incoming bit is valid this cycle
  input  wire logic       rx_crc_mf_out_of_sync_i, // Receive CRC multiframe out of sync
  input  wire logic       rx_crc_err_i,          // Receive CRC-4 error pulse
  input  wire logic       rx_crc_err_smf2_i,     // Error belongs to second submultiframe
  output logic            tx_bit_o,              // Outgoing bit with overhead
  output logic            tx_valid_o,            // Outgoing bit valid
  output logic            frame_start_o,         // Outgoing bit is first of a frame
  output logic            gen_basic_o,           // Basic frame generation active
  output logic            gen_crc_o,             // CRC multiframe generation active
  output logic            gen_mod_crc_o,         // Modified CRC multiframe active
  output logic            gen_sig_o              // Signalling multiframe active
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [6:0]  mode;
  logic [1:0]  intl;
  logic [4:0]  nat_en;
  e1_tx_overhead_pkg::codeword_t nat_cw [5];
  logic [2:0]  extra;
  logic [6:0]  act_mode;
  logic [1:0]  act_intl;
  logic [4:0]  act_nat_en;
  e1_tx_overhead_pkg::codeword_t act_cw [5];
  logic [2:0]  act_extra;
  logic [2:0]  bit_cnt;
  logic [4:0]  ts_cnt;
  logic [3:0]  frm_cnt;
  logic        e1_err;
  logic        e2_err;

  logic        bus_req;
  logic        hit;
  logic [31:0] next_rdata;
  logic        frame_end;
  logic        si_slot;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

  function automatic logic [31:0] byte_word(input logic [7:0] v);
    byte_word = {24'h000000, v};
  endfunction

  // True when the stream position equals the wanted timeslot and bit
  function automatic logic pos_is(input logic [4:0] ts, input logic [2:0] b,
                                  input logic [4:0] ts_want, input logic [2:0] b_want);
    pos_is = (ts == ts_want) && (b == b_want);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register read decode
  always_comb
  begin
    hit = 1'b1;
    next_rdata = 32'h00000000;
    unique case (wb_adr_i)
      `REG_MODE:  next_rdata = byte_word({1'b0, mode});
      `REG_INTL:  next_rdata = byte_word({6'h00, intl});
      `REG_NAT_EN: next_rdata = byte_word({3'h0, nat_en});
      `REG_NAT4:  next_rdata = byte_word({4'h0, nat_cw[0]});
      `REG_NAT5:  next_rdata = byte_word({4'h0, nat_cw[1]});
      `REG_NAT6:  next_rdata = byte_word({4'h0, nat_cw[2]});
      `REG_NAT7:  next_rdata = byte_word({4'h0, nat_cw[3]});
      `REG_NAT8:  next_rdata = byte_word({4'h0, nat_cw[4]});
      `REG_EXTRA: next_rdata = byte_word({4'h0, extra[2], 1'b0, extra[1:0]});
      `REG_POS:   next_rdata = {12'h000, frm_cnt, 3'h0, ts_cnt, 5'h00, bit_cnt};
      default:    hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req && hit;
      wb_err_o <= bus_req && !hit;
      if (bus_req && !wb_we_i)
        wb_dat_o <= next_rdata;
    end
  end

  // Register writes, byte lane 0 only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode   <= `MODE_RESET;
      intl   <= `INTL_RESET;
      nat_en <= `NAT_EN_RESET;
      extra  <= `EXTRA_RESET;
      for (int i = 0; i < 5; i++)
        nat_cw[i] <= `CODEWORD_RESET;
    end
    else if (bus_req && hit && wb_we_i && wb_sel_i[0])
    begin
      unique case (wb_adr_i)
        `REG_MODE:   mode   <= wb_dat_i[6:0];
        `REG_INTL:   intl   <= wb_dat_i[1:0];
        `REG_NAT_EN: nat_en <= wb_dat_i[4:0];
        `REG_NAT4:   nat_cw[0] <= wb_dat_i[3:0];
        `REG_NAT5:   nat_cw[1] <= wb_dat_i[3:0];
        `REG_NAT6:   nat_cw[2] <= wb_dat_i[3:0];
        `REG_NAT7:   nat_cw[3] <= wb_dat_i[3:0];
        `REG_NAT8:   nat_cw[4] <= wb_dat_i[3:0];
        `REG_EXTRA:  extra  <= {wb_dat_i[3], wb_dat_i[1:0]};
        default:     ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Position counters in the outgoing stream
  assign frame_end = tx_valid_i && pos_is(ts_cnt, bit_cnt, 5'h1F, 3'h7);
  // First bit of each frame, which carries the international or E bit
  assign si_slot   = pos_is(ts_cnt, bit_cnt, 5'h00, 3'h0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bit_cnt <= 3'h0;
      ts_cnt  <= 5'h00;
      frm_cnt <= 4'h0;
    end
    else if (tx_valid_i)
    begin
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7)
      begin
        ts_cnt <= ts_cnt + 5'h01;
        if (ts_cnt == 5'h1F)
          frm_cnt <= frm_cnt + 4'h1;
      end
    end
  end

  // Shadow copies load only at frame boundaries
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      act_mode   <= `MODE_RESET;
      act_intl   <= `INTL_RESET;
      act_nat_en <= `NAT_EN_RESET;
      act_extra  <= `EXTRA_RESET;
      for (int i = 0; i < 5; i++)
        act_cw[i] <= `CODEWORD_RESET;
    end
    else if (frame_end)
    begin
      act_mode   <= mode;
      act_intl   <= intl;
      act_nat_en <= nat_en;
      act_extra  <= extra;
      if (frm_cnt[2:0] == 3'h7)
        act_cw <= nat_cw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Generation modes
  logic basic_on;
  logic crc_on;
  logic sig_on;
  logic mod_crc;
  e1_tx_overhead_pkg::ebit_mode_t ebit_mode;

  assign basic_on = !act_mode[`MODE_FRAMING_OFF];
  assign crc_on   = basic_on && act_mode[`MODE_CRC_ON];
  assign sig_on   = basic_on && act_mode[`MODE_SIG_ON];
  assign mod_crc  = crc_on && act_mode[`MODE_MOD_CRC];

  always_comb
  begin
    if (!act_mode[`MODE_FEBE_KEEP])
      ebit_mode = rx_crc_mf_out_of_sync_i ? e1_tx_overhead_pkg::ebit_intl
                                          : e1_tx_overhead_pkg::ebit_zero_on_err;
    else
      ebit_mode = act_mode[`MODE_INTL_KEEP] ? e1_tx_overhead_pkg::ebit_keep
                                            : e1_tx_overhead_pkg::ebit_intl;
  end

  // Pending single-zero E bits; a new error wins over the consuming clear
  logic at_e1;
  logic at_e2;
  assign at_e1 = tx_valid_i && si_slot && frm_cnt == 4'hD;
  assign at_e2 = tx_valid_i && si_slot && frm_cnt == 4'hF;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      e1_err <= 1'b0;
      e2_err <= 1'b0;
    end
    else
    begin
      // First submultiframe error, sent as E1
      if (rx_crc_err_i && !rx_crc_err_smf2_i)
        e1_err <= 1'b1;
      else if (at_e1)
        e1_err <= 1'b0;
      // Second submultiframe error, sent as E2
      if (rx_crc_err_i && rx_crc_err_smf2_i)
        e2_err <= 1'b1;
      else if (at_e2)
        e2_err <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Overhead bit selection
  logic       next_bit;
  logic       fas;
  logic [2:0] sa_idx;
  logic [1:0] cw_idx;
  logic       e_slot;
  logic       e2_slot;
  logic       sa_slot;
  logic       x_slot;
  logic       ebit_val;
  logic       intl_val;
  logic       sa_val;
  logic       x_val;

  // Positions of the overhead fields inside the multiframe
  assign fas     = !frm_cnt[0];
  assign sa_idx  = 3'h7 - bit_cnt;
  assign cw_idx  = frm_cnt[2:1];
  assign e_slot  = si_slot && frm_cnt[3:2] == 2'h3 && frm_cnt[0];
  assign e2_slot = frm_cnt[1];
  assign sa_slot = ts_cnt == 5'h00 && !fas && bit_cnt >= 3'h3;
  assign x_slot  = ts_cnt == `TS16 && frm_cnt == 4'h0;

  // E bits of frames 13 and 15
  always_comb
  begin
    ebit_val = tx_bit_i;
    unique case (ebit_mode)
      e1_tx_overhead_pkg::ebit_zero_on_err:
        ebit_val = !(e2_slot ? e2_err : e1_err);
      e1_tx_overhead_pkg::ebit_intl:
        ebit_val = e2_slot ? act_intl[1] : act_intl[0];
      e1_tx_overhead_pkg::ebit_keep:
        ebit_val = tx_bit_i;
    endcase
  end

  // International bit of basic frames
  always_comb
  begin
    intl_val = tx_bit_i;
    if (!act_mode[`MODE_INTL_KEEP])
      intl_val = fas ? act_intl[0] : act_intl[1];
  end

  // National bits of non-alignment frames
  always_comb
  begin
    sa_val = tx_bit_i;
    if (sa_slot && act_nat_en[sa_idx])
    begin
      if (crc_on)
        sa_val = act_cw[3'h4 - sa_idx][2'h3 - cw_idx];
      else
        sa_val = act_cw[3'h4 - sa_idx][3];
    end
  end

  // Extra bits 5, 7 and 8 of timeslot 16 in frame 0
  always_comb
  begin
    x_val = tx_bit_i;
    if (bit_cnt == 3'h4)
      x_val = act_extra[2];
    else if (bit_cnt == 3'h6)
      x_val = act_extra[1];
    else if (bit_cnt == 3'h7)
      x_val = act_extra[0];
  end

  always_comb
  begin
    next_bit = tx_bit_i;
    if (basic_on && si_slot)
    begin
      if (crc_on && e_slot)
        next_bit = ebit_val;
      else if (!crc_on)
        next_bit = intl_val;
    end
    else if (basic_on && sa_slot)
      next_bit = sa_val;
    else if (sig_on && !act_mode[`MODE_EXTRA_KEEP] && x_slot)
      next_bit = x_val;
  end

  // One-cycle pipeline toward the line
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_bit_o      <= 1'b0;
      tx_valid_o    <= 1'b0;
      frame_start_o <= 1'b0;
    end
    else
    begin
      tx_bit_o      <= next_bit;
      tx_valid_o    <= tx_valid_i;
      frame_start_o <= tx_valid_i && si_slot;
    end
  end

  // Active generation modes, as loaded at the last frame boundary
  assign gen_basic_o   = basic_on;
  assign gen_crc_o     = crc_on;
  assign gen_mod_crc_o = mod_crc;
  assign gen_sig_o     = sig_on;

endmodule

// >>> testbench/e1_tx_overhead_asserts.sv
// Port assertions for the E1 transmit overhead block
`timescale 1ns/1ps
module e1_tx_chk
(
  input wire logic       clk_i,         // Clock
  input wire logic       rst_i,         // Reset
  input wire logic       wb_cyc_i,      // Cycle
  input wire logic       wb_stb_i,      // Strobe
  input wire logic [7:0] wb_adr_i,      // Address
  input wire logic       wb_ack_o,      // Ack
  input wire logic       wb_err_o,      // Error
  input wire logic       tx_bit_i,      // Bit in
  input wire logic       tx_valid_i,    // Valid in
  input wire logic       tx_bit_o,      // Bit out
  input wire logic       tx_valid_o,    // Valid out
  input wire logic       frame_start_o, // Frame start
  input wire logic       gen_basic_o,   // Basic on
  input wire logic       gen_crc_o,     // CRC on
  input wire logic       gen_mod_crc_o, // Modified CRC
  input wire logic       gen_sig_o      // Signalling on
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic bus_req;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  sequence answer;
    (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
  endsequence
  a_bus_answer: assert property (bus_req |=> answer)
    else $error("bus answer missing or too long");
  a_mapped_ack: assert property (bus_req && wb_adr_i inside {[8'h62:8'h6A]} |=> wb_ack_o)
    else $error("mapped register not acknowledged");
  a_unmapped_err: assert property (bus_req && wb_adr_i > 8'h70 |=> wb_err_o)
    else $error("unmapped address not refused");
  a_valid_lat: assert property (tx_valid_i |=> tx_valid_o)
    else $error("valid not passed after one cycle");
  a_start_valid: assert property (frame_start_o |-> tx_valid_o)
    else $error("frame start without valid bit");
  a_mod_crc: assert property (gen_mod_crc_o |-> gen_crc_o)
    else $error("modified crc without crc multiframe");
  a_framing_off: assert property (!gen_basic_o |-> !gen_crc_o && !gen_sig_o)
    else $error("multiframe generated with framing off");
  a_off_pass: assert property (!gen_basic_o && !$past(gen_basic_o) && tx_valid_i ##1
    !gen_basic_o |-> tx_bit_o == $past(tx_bit_i))
    else $error("bit altered with framing off");
  a_reset_mode: assert property ($fell(rst_i) |-> gen_basic_o && gen_crc_o && gen_sig_o
    && !gen_mod_crc_o)
    else $error("wrong generation mode after reset");
endmodule

bind e1_tx_overhead_insertion e1_tx_chk e1_tx_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .tx_bit_i(tx_bit_i), .tx_valid_i(tx_valid_i), .tx_bit_o(tx_bit_o),
  .tx_valid_o(tx_valid_o), .frame_start_o(frame_start_o), .gen_basic_o(gen_basic_o),
  .gen_crc_o(gen_crc_o), .gen_mod_crc_o(gen_mod_crc_o), .gen_sig_o(gen_sig_o));

// >>> testbench/e1_line_sink.sv
// Line-side sink recording each multiframe of the outgoing stream
`timescale 1ns/1ps
module e1_line_sink
(
  input wire logic clk_i,   // Clock
  input wire logic rst_i,   // Reset
  input wire logic bit_i,   // Line bit
  input wire logic valid_i, // Bit valid
  input wire logic fs_i     // Frame start
);
  logic [4095:0] mem;
  logic [11:0]   pos;
  logic [11:0]   next_pos;
  // Frame number in the top nibble, bit position below
  assign next_pos = fs_i ? {pos[11:8] + 4'h1, 8'h00} : pos + 12'h001;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pos <= 12'hFFF;
    else if (valid_i)
    begin
      pos <= next_pos;
      mem[next_pos] <= bit_i;
    end
  end
endmodule

// >>> testbench/test_e1_tx_overhead_insertion.sv
// Self-checking bench for the E1 transmit overhead block
`timescale 1ns/1ps
module test_e1_tx_overhead_insertion;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        fill = 1'b0;
  logic        vin = 1'b1;
  logic        oos = 1'b1;
  logic        crc_err = 1'b0;
  logic        smf2 = 1'b0;
  logic [31:0] rdat;
  logic        ack, berr, tbit, tval, fs, gb, gc, gm, gs, be;
  logic [7:0]  rd;
  int          err_total = 0;
  int          tests_run = 0;
  always #12.5 clk_i = ~clk_i;
  e1_tx_overhead_insertion e1_tx_overhead_insertion_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(berr), .tx_bit_i(fill),
    .tx_valid_i(vin), .rx_crc_mf_out_of_sync_i(oos), .rx_crc_err_i(crc_err),
    .rx_crc_err_smf2_i(smf2), .tx_bit_o(tbit), .tx_valid_o(tval), .frame_start_o(fs),
    .gen_basic_o(gb), .gen_crc_o(gc), .gen_mod_crc_o(gm), .gen_sig_o(gs));
  e1_line_sink e1_line_sink_inst (.clk_i(clk_i), .rst_i(rst_i), .bit_i(tbit),
    .valid_i(tval), .fs_i(fs));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d = 8'h00);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do
      @(posedge clk_i);
    while (ack !== 1'b1 && berr !== 1'b1);
    rd = rdat[7:0];
    be = berr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Long enough for a codeword change plus one full multiframe
  task automatic settle;
    repeat (6144) @(posedge clk_i);
  endtask
  function automatic logic lb(input int f, input int p);
    return e1_line_sink_inst.mem[f * 256 + p];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] ex [9] = '{8'h06, 8'h03, 8'h00, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0B};
    vin <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(tval, 1'b0);
    vin <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      bus(1'b0, 8'h62 + i[7:0]);
      chk(rd, ex[i]);
    end
    bus(1'b0, 8'h7F);
    chk(be, 1'b1);
  endtask
  task automatic t_intl;
    bus(1'b1, 8'h62, 8'h00);
    bus(1'b1, 8'h63, 8'h02);
    fill <= 1'b1;
    settle;
    chk({lb(0, 0), lb(1, 0)}, 2'b01);
    bus(1'b1, 8'h62, 8'h20);
    bus(1'b1, 8'h63, 8'h00);
    settle;
    chk({lb(2, 0), lb(3, 0)}, 2'b11);
  endtask
  task automatic t_sa;
    bus(1'b1, 8'h62, 8'h00);
    fill <= 1'b0;
    for (int k = 0; k < 5; k++)
      bus(1'b1, 8'h65 + k[7:0], k[0] ? 8'h00 : 8'h08);
    bus(1'b1, 8'h64, 8'h1F);
    settle;
    chk({lb(3, 3), lb(3, 4), lb(3, 5), lb(3, 6), lb(3, 7)}, 5'h15);
    for (int k = 0; k < 5; k++)
      bus(1'b1, 8'h65 + k[7:0], 8'h08);
    bus(1'b1, 8'h64, 8'h0A);
    settle;
    chk({lb(5, 3), lb(5, 4), lb(5, 5), lb(5, 6), lb(5, 7)}, 5'h0A);
  endtask
  task automatic t_crc;
    bus(1'b1, 8'h62, 8'h02);
    bus(1'b1, 8'h64, 8'h08);
    bus(1'b1, 8'h66, 8'h0A);
    settle;
    for (int f = 1; f < 16; f += 2)
      chk(lb(f, 4), (4'hA >> (3 - (f % 8) / 2)) & 4'h1);
  endtask
  task automatic t_ebit;
    fill <= 1'b1;
    for (int v = 1; v < 3; v++)
    begin
      bus(1'b1, 8'h63, v[7:0]);
      settle;
      chk({lb(13, 0), lb(15, 0)}, {v[0], v[1]});
    end
    bus(1'b1, 8'h62, 8'h32);
    settle;
    chk({lb(13, 0), lb(15, 0)}, 2'b11);
    bus(1'b1, 8'h62, 8'h12);
    oos <= 1'b0;
    settle;
    chk({lb(13, 0), lb(15, 0)}, 2'b01);
    bus(1'b1, 8'h62, 8'h02);
    oos <= 1'b0;
    settle;
    for (int s = 0; s < 2; s++)
    begin
      wait (e1_line_sink_inst.pos[11:8] == 4'h0);
      @(posedge clk_i);
      crc_err <= 1'b1;
      smf2 <= s[0];
      @(posedge clk_i);
      crc_err <= 1'b0;
      wait (e1_line_sink_inst.pos[11:8] == 4'hF);
      wait (e1_line_sink_inst.pos[11:8] == 4'h0);
      chk({lb(13, 0), lb(15, 0)}, s[0] ? 2'b10 : 2'b01);
    end
  endtask
  task automatic t_extra;
    bus(1'b1, 8'h6A, 8'h08);
    bus(1'b1, 8'h62, 8'h04);
    settle;
    chk({lb(0, 132), lb(0, 133), lb(0, 134), lb(0, 135)}, 4'hC);
    bus(1'b1, 8'h62, 8'h44);
    settle;
    chk({lb(0, 132), lb(0, 133), lb(0, 134), lb(0, 135)}, 4'hF);
  endtask
  task automatic t_gen;
    logic [7:0] md [4] = '{8'h01, 8'h08, 8'h0A, 8'h0F};
    logic [3:0] ex [4] = '{4'h0, 4'h8, 4'hE, 4'h0};
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h62, md[i]);
      repeat (512) @(posedge clk_i);
      chk({gb, gc, gm, gs}, ex[i]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_intl;
    t_sa;
    t_crc;
    t_ebit;
    t_extra;
    t_gen;
    wrap_up;
  end
  initial
  begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    wrap_up;
  end
endmodule
